// file: block_counter.v
// Block counter: software load, decrement per finished block
`timescale 1ns/100ps
module block_counter #(
  parameter CNT_W = 16
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             load,
  input  wire [CNT_W-1:0] load_val,
  input  wire             dec,
  output reg  [CNT_W-1:0] count_r,
  output wire             is_zero,
  output wire             is_one
);
  assign is_zero = (count_r == {CNT_W{1'b0}});
  assign is_one  = (count_r == {{(CNT_W-1){1'b0}}, 1'b1});

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= {CNT_W{1'b0}};
    end else if (load) begin
      count_r <= load_val;
    end else if (dec && !is_zero) begin
      count_r <= count_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// file: sd_card_model.sv
// Behavioural card: answers each command, then returns blocks while data runs
`timescale 1ns/100ps
module sd_card_model (
  input  wire       cmd_start,
  input  wire [5:0] cmd_index,
  input  wire       xfer_active,
  input  wire       err_inj,
  input  wire       slow,
  output reg        sd_clk = 1'b0,
  output reg        blk_end = 1'b0,
  output reg        cmd_done = 1'b0,
  output reg        cmd_err = 1'b0
);
  // Link clock runs only inside a frame and rests low between them
  task tick;
    begin
      #32 sd_clk = 1'b1;
      #32 sd_clk = 1'b0;
    end
  endtask
  always begin
    wait (cmd_start === 1'b1);
    repeat (slow ? 6 : 2) tick;
    cmd_err = err_inj && (cmd_index == 6'h0c);
    cmd_done = 1'b1;
    tick;
    cmd_done = 1'b0;
    // Released line shows the inverse, so a stale sample cannot pass
    cmd_err = !cmd_err;
    tick;
    while (xfer_active === 1'b1 && cmd_start !== 1'b1) begin
      repeat (slow ? 3 : 1) tick;
      if (xfer_active === 1'b1 && cmd_start !== 1'b1) begin
        blk_end = 1'b1;
        tick;
        blk_end = 1'b0;
      end
    end
  end
endmodule

// file: sd_tm_defines.vh
// Register map, field positions and codes for the transfer mode control block
`ifndef SD_TM_DEFINES_VH
`define SD_TM_DEFINES_VH
`define OFS_BLOCK_COUNT   8'h04
`define OFS_TRANSFER_MODE 8'h0c
`define OFS_COMMAND       8'h10
`define OFS_INT_STATUS    8'h14
`define OFS_INT_MASK      8'h18
`define OFS_AUTO_CMD_ERR  8'h1c
`define OFS_PRESENT_STATE 8'h20
`define TM_DMA            0
`define TM_BLOCK_COUNT_ENABLE           1
`define TM_ACMD_LO        2
`define TM_ACMD_HI        3
`define TM_DIR            4
`define TM_MULTI          5
`define TM_MASK           16'h003f
`define TM_RESET          16'h0000
`define AUTO_CMD12        2'h1
`define STOP_CMD_INDEX    6'h0c
`define CMD_DATA_PRESENT  8
`define CMD_NEEDS_STOP    9
`define INT_XFER_DONE     0
`define INT_ACMD_ERR      1
`define INT_BLOCK_END     2
`define XT_SINGLE         2'h0
`define XT_INFINITE       2'h1
`define XT_MULTIPLE       2'h2
`define XT_STOP_MULTI     2'h3
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// file: sd_tm_monitor.sv
// Bus and sequencing assertions for the transfer mode block
`timescale 1ns/100ps
module sd_tm_monitor (
  input wire        clk,
  input wire        reset_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        cmd_done,
  input wire        cmd_start,
  input wire [5:0]  cmd_index,
  input wire        xfer_dir,
  input wire        dma_en,
  input wire        xfer_active
);
  // Cycles since the card last showed a response; saturates
  reg [3:0] since_done_r;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      since_done_r <= 4'hf;
    else if (cmd_done)
      since_done_r <= 4'h0;
    else if (since_done_r != 4'hf)
      since_done_r <= since_done_r + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while response pending");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("no read response");
  chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  chk_start_data: assert property ($rose(xfer_active) |-> ##[0:1] cmd_start)
    else $error("data transfer without command");
  chk_dir_hold: assert property (xfer_active [*2] |=>
    !xfer_active || ($stable(xfer_dir) && $stable(dma_en))) else $error("mode moved mid transfer");
  chk_stop_index: assert property ($rose(cmd_start) && $past(xfer_active, 2)
    |-> cmd_index == 6'h0c) else $error("non-stop command mid transfer");
  chk_stop_done: assert property ($fell(cmd_start) |-> since_done_r < 4'ha)
    else $error("command dropped without response");
  chk_done_drop: assert property ($rose(cmd_done) |-> ##[1:24] !cmd_start)
    else $error("command held after response");
endmodule
bind sd_transfer_mode_control sd_tm_monitor i_sd_tm_monitor (.*);

// file: sd_transfer_mode_control.v
// Transfer mode control register bank with AXI4-Lite slave and data transfer sequencer
//
// Functional notes
// - Writes to the transfer mode register are ignored while the data command inhibit is set.
// - Transfer type is single, infinite, multiple or stop-multiple from select, enable and count.
// - Direction bit zero moves data to the card, one moves data from the card to the controller.
// - With auto field at one, CMD12 is issued after the last block of a multiple (count-enabled) transfer and its error is recorded.
// - No automatic stop is issued for a command that does not need CMD12.
`timescale 1ns/100ps
`include "sd_tm_defines.vh"
module sd_transfer_mode_control #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 16
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              sd_clk,
  input  wire              blk_end,
  input  wire              cmd_done,
  input  wire              cmd_err,
  output reg               irq,
  output reg               cmd_start,
  output reg  [5:0]        cmd_index,
  output reg               xfer_dir,
  output reg               dma_en,
  output reg               xfer_active
);
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_XFER  = 3'h2;
  localparam [2:0] ST_ASTOP = 3'h4;
  function hit;
    input [ADDR_W-1:0] a;
    input [7:0]        ofs;
    begin
      hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    end
  endfunction
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] d;
    input [1:0]  strb;
    begin
      merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    end
  endfunction
  function [1:0] xfer_type;
    input multi;
    input block_count_enable;
    input cnt_zero;
    begin
      if (!multi) begin
        xfer_type = `XT_SINGLE;
      end else if (!block_count_enable) begin
        xfer_type = `XT_INFINITE;
      end else if (!cnt_zero) begin
        xfer_type = `XT_MULTIPLE;
      end else begin
        xfer_type = `XT_STOP_MULTI;
      end
    end
  endfunction
  wire        rst_n_s;
  reg  [ADDR_W-1:0] aw_addr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg  [15:0] tm_r;
  reg  [2:0]  ist_r;
  reg  [2:0]  imsk_r;
  reg         ace_r;
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [1:0]  xt_r;
  reg  [1:0]  xt_nxt;
  reg         needs_stop_r;
  reg         needs_stop_nxt;
  reg         inhibit_nxt;
  reg         start_nxt;
  reg  [5:0]  index_nxt;
  reg         dir_nxt;
  reg         dma_nxt;
  reg  [2:0]  ist_set;
  reg         ace_nxt;
  reg         cnt_dec;
  reg         sd_clk_d_r;
  wire [3:0]  link_s;
  wire        sd_rise;
  wire        blk_ev;
  wire        done_ev;
  wire        wr_go;
  wire        wr_cmd;
  wire        cnt_load;
  wire [CNT_W-1:0] cnt;
  wire        cnt_zero;
  wire        cnt_one;
  wire        last_blk;
  // Reset is released through two flops so every flop leaves reset on the same edge
  sync2 #(.W(1)) u_rst_sync (
    .clk   (clk),
    .rst_n (reset_n),
    .d     (1'b1),
    .q     (rst_n_s)
  );
  // Card clock and card-side strobes are sampled; strobes count only at a card clock rise
  sync2 #(.W(4)) u_link_sync (
    .clk   (clk),
    .rst_n (rst_n_s),
    .d     ({cmd_err, cmd_done, blk_end, sd_clk}),
    .q     (link_s)
  );
  assign sd_rise = link_s[0] & ~sd_clk_d_r;
  assign blk_ev  = sd_rise & link_s[1];
  assign done_ev = sd_rise & link_s[2];
  assign wr_go    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_cmd   = wr_go & hit(aw_addr_r, `OFS_COMMAND);
  // Count cannot be loaded while a data transfer owns it; only block ends decrement it
  assign cnt_load = wr_go & hit(aw_addr_r, `OFS_BLOCK_COUNT) & ~xfer_active;
  block_counter #(.CNT_W(CNT_W)) u_count (
    .clk      (clk),
    .rst_n    (rst_n_s),
    .load     (cnt_load),
    .load_val (merge16(cnt, wdata_r[15:0], wstrb_r[1:0])),
    .dec      (cnt_dec),
    .count_r  (cnt),
    .is_zero  (cnt_zero),
    .is_one   (cnt_one)
  );
  assign last_blk = (xt_r == `XT_SINGLE) | ((xt_r == `XT_MULTIPLE) & cnt_one);
  always @* begin
    state_nxt      = state_r;
    xt_nxt         = xt_r;
    needs_stop_nxt = needs_stop_r;
    inhibit_nxt    = xfer_active;
    start_nxt      = cmd_start & ~done_ev;
    index_nxt      = cmd_index;
    dir_nxt        = xfer_dir;
    dma_nxt        = dma_en;
    ist_set        = 3'h0;
    ace_nxt        = ace_r;
    cnt_dec        = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (wr_cmd) begin
          start_nxt = 1'b1;
          index_nxt = wdata_r[5:0];
          if (wdata_r[`CMD_DATA_PRESENT]) begin
            state_nxt      = ST_XFER;
            inhibit_nxt    = 1'b1;
            needs_stop_nxt = wdata_r[`CMD_NEEDS_STOP];
            xt_nxt         = xfer_type(tm_r[`TM_MULTI], tm_r[`TM_BLOCK_COUNT_ENABLE], cnt_zero);
            dir_nxt        = tm_r[`TM_DIR];
            dma_nxt        = tm_r[`TM_DMA];
          end
        end
      end
      ST_XFER: begin
        if (wr_cmd && wdata_r[5:0] == `STOP_CMD_INDEX) begin
          // Software abort of any running transfer by a stop command
          start_nxt   = 1'b1;
          index_nxt   = `STOP_CMD_INDEX;
          state_nxt   = ST_IDLE;
          inhibit_nxt = 1'b0;
          ist_set[`INT_XFER_DONE] = 1'b1;
        end else if (xt_r == `XT_STOP_MULTI) begin
          // Zero count: nothing to move, ends with the command response
          if (done_ev) begin
            state_nxt   = ST_IDLE;
            inhibit_nxt = 1'b0;
            ist_set[`INT_XFER_DONE] = 1'b1;
          end
        end else if (blk_ev) begin
          ist_set[`INT_BLOCK_END] = 1'b1;
          cnt_dec = tm_r[`TM_BLOCK_COUNT_ENABLE];
          if (last_blk) begin
            if (xt_r == `XT_MULTIPLE && needs_stop_r &&
                tm_r[`TM_ACMD_HI:`TM_ACMD_LO] == `AUTO_CMD12) begin
              state_nxt = ST_ASTOP;
              start_nxt = 1'b1;
              index_nxt = `STOP_CMD_INDEX;
            end else begin
              state_nxt   = ST_IDLE;
              inhibit_nxt = 1'b0;
              ist_set[`INT_XFER_DONE] = 1'b1;
            end
          end
        end
      end
      ST_ASTOP: begin
        if (done_ev) begin
          ace_nxt     = link_s[3];
          state_nxt   = ST_IDLE;
          inhibit_nxt = 1'b0;
          ist_set[`INT_XFER_DONE] = 1'b1;
          ist_set[`INT_ACMD_ERR]  = link_s[3];
        end
      end
      default: begin
        state_nxt   = ST_IDLE;
        inhibit_nxt = 1'b0;
      end
    endcase
  end
  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r      <= ST_IDLE;
      xt_r         <= `XT_SINGLE;
      needs_stop_r <= 1'b0;
      xfer_active  <= 1'b0;
      cmd_start    <= 1'b0;
      cmd_index    <= 6'h00;
      xfer_dir     <= 1'b0;
      dma_en       <= 1'b0;
      ace_r        <= 1'b0;
      tm_r         <= `TM_RESET;
      ist_r        <= 3'h0;
      imsk_r       <= 3'h0;
      irq          <= 1'b0;
      sd_clk_d_r   <= 1'b0;
    end else begin
      sd_clk_d_r   <= link_s[0];
      state_r      <= state_nxt;
      xt_r         <= xt_nxt;
      needs_stop_r <= needs_stop_nxt;
      xfer_active  <= inhibit_nxt;
      cmd_start    <= start_nxt;
      cmd_index    <= index_nxt;
      xfer_dir     <= dir_nxt;
      dma_en       <= dma_nxt;
      ace_r        <= ace_nxt;
      if (wr_go && hit(aw_addr_r, `OFS_TRANSFER_MODE) && !xfer_active) begin
        tm_r <= merge16(tm_r, wdata_r[15:0], wstrb_r[1:0]) & `TM_MASK;
      end
      if (wr_go && hit(aw_addr_r, `OFS_INT_MASK) && wstrb_r[0]) begin
        imsk_r <= wdata_r[2:0];
      end
      // A new event in the clearing cycle stays set
      if (wr_go && hit(aw_addr_r, `OFS_INT_STATUS) && wstrb_r[0]) begin
        ist_r <= (ist_r & ~wdata_r[2:0]) | ist_set;
      end else begin
        ist_r <= ist_r | ist_set;
      end
      irq <= |(ist_r & imsk_r);
    end
  end
  // Write channel: address and data taken in either order, response after both
  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_addr_r     <= {ADDR_W{1'b0}};
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_awready <= 1'b0;
        aw_addr_r     <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        s_axi_wready <= 1'b0;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (hit(aw_addr_r, `OFS_BLOCK_COUNT) || hit(aw_addr_r, `OFS_TRANSFER_MODE) ||
            hit(aw_addr_r, `OFS_COMMAND) || hit(aw_addr_r, `OFS_INT_STATUS) ||
            hit(aw_addr_r, `OFS_INT_MASK) || hit(aw_addr_r, `OFS_AUTO_CMD_ERR) ||
            hit(aw_addr_r, `OFS_PRESENT_STATE)) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  // Read channel: data one cycle after the address is taken
  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      if (hit(s_axi_araddr, `OFS_BLOCK_COUNT)) begin
        s_axi_rdata <= {{(32-CNT_W){1'b0}}, cnt};
      end else if (hit(s_axi_araddr, `OFS_TRANSFER_MODE)) begin
        s_axi_rdata <= {16'h0000, tm_r};
      end else if (hit(s_axi_araddr, `OFS_COMMAND)) begin
        s_axi_rdata <= {16'h0000, 6'h00, needs_stop_r, xfer_active, 2'h0, cmd_index};
      end else if (hit(s_axi_araddr, `OFS_INT_STATUS)) begin
        s_axi_rdata <= {29'h00000000, ist_r};
      end else if (hit(s_axi_araddr, `OFS_INT_MASK)) begin
        s_axi_rdata <= {29'h00000000, imsk_r};
      end else if (hit(s_axi_araddr, `OFS_AUTO_CMD_ERR)) begin
        s_axi_rdata <= {31'h00000000, ace_r};
      end else if (hit(s_axi_araddr, `OFS_PRESENT_STATE)) begin
        s_axi_rdata <= {28'h0000000, xt_r, cmd_start, xfer_active};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// file: sync2.v
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
module sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// file: tb_sd_transfer_mode_control.sv
// Self-checking bench for the transfer mode control block
`timescale 1ns/100ps
module tb_sd_transfer_mode_control;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [15:0] d;
    logic [15:0] e;
    logic [1:0]  r;
  } row_t;
  reg          clk = 1'b0, reset_n = 1'b0, err_inj = 1'b0, slow = 1'b0, start_q = 1'b0;
  reg          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0]  s_axi_wdata = 32'h0;
  reg  [3:0]   s_axi_wstrb = 4'hf;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         sd_clk, blk_end, cmd_done, cmd_err, irq, cmd_start, xfer_dir, dma_en, xfer_active;
  wire [5:0]   cmd_index;
  integer      n_mismatch = 0, checks = 0, n_stop = 0, i;
  logic [31:0] d;
  logic [1:0]  r;
  row_t        rows [13] = '{
    '{0, 8'h0c, 16'h0, 16'h0, 2'h0}, '{1, 8'h0c, 16'hffff, 16'h3f, 2'h0},
    '{1, 8'h0c, 16'h0, 16'h0, 2'h0}, '{0, 8'h20, 16'h0, 16'h0, 2'h0},
    '{1, 8'h0c, 16'h20, 16'h20, 2'h0}, '{0, 8'h20, 16'h0, 16'h0, 2'h0},
    '{1, 8'h0c, 16'h22, 16'h22, 2'h0}, '{1, 8'h04, 16'h0, 16'h0, 2'h0},
    '{0, 8'h20, 16'h0, 16'h0, 2'h0}, '{1, 8'h04, 16'h3, 16'h3, 2'h0},
    '{0, 8'h20, 16'h0, 16'h0, 2'h0}, '{1, 8'h30, 16'h1234, 16'h0, 2'h2},
    '{1, 8'h18, 16'h5, 16'h5, 2'h0}};
  sd_transfer_mode_control i_sd_transfer_mode_control (.*);
  sd_card_model i_sd_card_model (.*);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    start_q <= cmd_start;
    if (cmd_start && !start_q && cmd_index === 6'h0c)
      n_stop <= n_stop + 1;
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Address and data are offered together; each is dropped at its own ready
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
        begin
          do @(posedge clk); while (s_axi_awready !== 1'b1);
          s_axi_awvalid <= 1'b0;
        end
        begin
          do @(posedge clk); while (s_axi_wready !== 1'b1);
          s_axi_wvalid <= 1'b0;
        end
      join
      while (s_axi_bvalid !== 1'b1) @(posedge clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task run(input [15:0] tm, bc, cm, input [2:0] mk, st, input inf, input integer stops);
    integer s0, n;
    begin
      wr(8'h18, mk);
      wr(8'h0c, tm);
      wr(8'h04, bc);
      s0 = n_stop;
      wr(8'h10, cm);
      repeat (3) @(posedge clk);
      chk("active", xfer_active, 1);
      chk("dir dma", {xfer_dir, dma_en}, {tm[4], tm[0]});
      wr(8'h0c, 32'h0);
      rd(8'h0c);
      chk("locked", d, tm);
      // Transfer type is latched at the data command and shown in present state
      rd(8'h20);
      chk("type", d[3:2], {tm[5] & tm[1], tm[5] & (!tm[1] || bc == 16'h0)});
      if (inf) begin
        repeat (400) @(posedge clk);
        wr(8'h10, 32'h0c);
      end
      n = 0;
      // A pending stop response must finish before the next command is issued
      while ((xfer_active !== 1'b0 || cmd_start !== 1'b0) && n < 4000) begin
        @(posedge clk);
        n = n + 1;
      end
      chk("ended", {xfer_active, cmd_start}, 0);
      // Interrupt output trails the status by a cycle
      repeat (4) @(posedge clk);
      chk("stops", n_stop - s0, stops);
      chk("irq", irq, |(st & mk));
      rd(8'h14);
      chk("status", d, st);
      wr(8'h14, 32'h7);
      repeat (3) @(posedge clk);
      chk("irq clear", irq, 0);
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 13; i = i + 1) begin
      if (rows[i].wr) begin
        wr(rows[i].a, {16'h0, rows[i].d});
        chk("bresp", r, rows[i].r);
      end
      rd(rows[i].a);
      chk("rdata", d, {16'h0, rows[i].e});
      chk("rresp", r, rows[i].r);
    end
    slow <= 1'b1;
    err_inj <= 1'b1;
    run(16'h37, 16'h3, 16'h312, 3'h7, 3'h7, 1'b0, 1);
    rd(8'h1c);
    chk("auto err", d, 1);
    rd(8'h04);
    chk("count", d, 0);
    slow <= 1'b0;
    err_inj <= 1'b0;
    run(16'h26, 16'h2, 16'h112, 3'h5, 3'h5, 1'b0, 0);
    rd(8'h1c);
    chk("auto err kept", d, 1);
    run(16'h30, 16'h5, 16'h112, 3'h1, 3'h5, 1'b1, 1);
    rd(8'h04);
    chk("count held", d, 5);
    run(16'h04, 16'h0, 16'h312, 3'h0, 3'h5, 1'b0, 0);
    run(16'h26, 16'h0, 16'h312, 3'h7, 3'h1, 1'b0, 0);
    rd(8'h0c);
    wr(8'h0c, 32'h0);
    wr(8'h0c, d);
    rd(8'h0c);
    chk("restored", d, 16'h26);
    wr(8'h0c, 32'h30);
    wr(8'h10, 32'h112);
    repeat (100) @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset active", xfer_active, 0);
    rd(8'h0c);
    chk("reset mode", d, 0);
    give_verdict;
  end
endmodule
